// [core/fbm_core.sv]
// flash bank mode control, command entry and host bus sequencing
// Summary of operation
// R1: one bank at most in algorithm or overlay
// R2: all banks return to read mode
// R3: ready pin marks valid data, polarity configurable
// R4: not-ready means data invalid, host waits
// R5: modes entered only by command writes
// R6: host sends reset after bad sequences
// R7: algorithm bank gives status, never array data
// R8: other banks keep serving reads meanwhile
// R9: second mode entry is ignored
// R10: host finishes background work before overlays
// R11: overlay shows only in its sector
// R12: only overlay area programmable, bank goes algorithm
// R13: id and factory otp programs fail
// R14: write latched at write strobe rising edge
// R15: burst address captured with address valid low
// R16: burst data out, address advances each clock
// R17: no data before initial access count
// R18: config bit 15 one selects async, default
// R19: host holds write high during async address
// R20: address latched on address valid rising edge
// R21: drive data only when selected and enabled
// R22: config bit 15 zero selects burst
// R23: f0 write removes identification overlay
// R24: deselect or reset floats the bus
`timescale 1ns/100ps
module fbm_core
#(
    parameter int BANK_W = 2,
    parameter int ACC_CYC = fbm_pkg::ACC_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus pins
    input wire logic hw_reset_n_i,
    input wire logic chip_sel_n_i,
    input wire logic out_en_n_i,
    input wire logic write_en_n_i,
    input wire logic address_valid_n_i,
    input wire logic bus_clk_i,
    input wire logic [fbm_pkg::UPPER_W-1:0] upper_address_i,
    input wire logic [fbm_pkg::DATA_W-1:0] muxed_addr_data_i,
    output logic [fbm_pkg::DATA_W-1:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe_o,
    output logic ready_o,
    // array read port, data valid one clock after the address
    output logic [fbm_pkg::ADDR_W-1:0] array_addr_o,
    output fbm_pkg::fbm_space_type array_space_o,
    input wire logic [fbm_pkg::DATA_W-1:0] array_data_i,
    // algorithm engine
    output logic prog_req_o,
    output logic erase_req_o,
    output logic [fbm_pkg::ADDR_W-1:0] prog_addr_o,
    output logic [fbm_pkg::DATA_W-1:0] prog_data_o,
    output fbm_pkg::fbm_space_type prog_space_o,
    input wire logic algo_done_i,
    input wire logic algo_fail_i,
    // bank status
    output logic [BANK_W-1:0] active_bank_o,
    output fbm_pkg::fbm_mode_type bank_mode_o
);
    import fbm_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] pin;
        fbm_bus_type bus;
        logic [ADDR_W-1:0] addr;
        logic [4:0] cnt;
        logic [DATA_W-1:0] cfg;
        logic [BANK_W-1:0] act_bank;
        fbm_mode_type mode;
        logic [UPPER_W-1:0] ovl_sect;
        fbm_space_type ovl;
        logic prog_armed;
        logic status_armed;
        logic fail;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic ready;
        logic [ADDR_W-1:0] arr_addr;
        fbm_space_type arr_space;
        logic prog_req;
        logic erase_req;
        logic [ADDR_W-1:0] prog_addr;
        logic [DATA_W-1:0] prog_data;
        fbm_space_type prog_space;
    } fbm_state_type;

    fbm_state_type st;
    fbm_state_type next_st;

    logic [PIN_W-1:0] filt;
    logic sel;
    logic rd_en;
    logic avd_lo;
    logic we_hi;
    logic avd_rise;
    logic we_rise;
    logic bclk_rise;
    logic async_mode;
    logic [4:0] iac_last;
    logic [ADDR_W-1:0] pin_addr;
    logic [DATA_W-1:0] wdata;

    // bank number held in the top address bits
    function automatic logic [BANK_W-1:0] bank_of(
        input logic [ADDR_W-1:0] a);
        bank_of = a[ADDR_W-1 -: BANK_W];
    endfunction : bank_of

    // sector number is the upper address field
    function automatic logic [UPPER_W-1:0] sect_of(
        input logic [ADDR_W-1:0] a);
        sect_of = a[ADDR_W-1 -: UPPER_W];
    endfunction : sect_of

    // overlay space only inside the selected sector
    function automatic fbm_space_type space_of(
        input fbm_state_type s,
        input logic [ADDR_W-1:0] a);
        if (s.mode == M_OVL && sect_of(a) == s.ovl_sect)
            space_of = s.ovl; // [R11]
        else
            space_of = SP_ARRAY;
    endfunction : space_of

    // word returned to a host read at address a
    function automatic logic [DATA_W-1:0] read_word(
        input fbm_state_type s,
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] arr);
        logic [DATA_W-1:0] w;
        logic own;
        w = '0;
        own = bank_of(a) == s.act_bank;
        w[ST_READY] = !(own && s.mode == M_ALGO);
        w[ST_FAIL] = s.fail;
        if (own && s.mode == M_ALGO)
            read_word = s.status_armed ? w : '0; // [R7]
        else if (s.status_armed && own)
            read_word = w;
        else if (space_of(s, a) == SP_CFG)
            read_word = s.cfg;
        else
            read_word = arr; // [R8]
    endfunction : read_word

    // a change counts once the second and third stages agree
    assign filt = (st.s2 & st.s3) | (st.pin & (st.s2 ^ st.s3));
    assign sel = !filt[P_CS];
    assign rd_en = !filt[P_OE];
    assign avd_lo = !filt[P_AVD];
    assign we_hi = filt[P_WE];
    assign avd_rise = filt[P_AVD] && !st.pin[P_AVD];
    assign we_rise = filt[P_WE] && !st.pin[P_WE];
    assign bclk_rise = filt[P_BCLK] && !st.pin[P_BCLK];
    assign async_mode = st.cfg[CFG_ASYNC]; // [R18] [R22]
    assign iac_last = 5'(st.cfg[CFG_IAC_HI:CFG_IAC_LO]) + IAC_OFS - 5'h01;
    assign pin_addr = {filt[P_UA +: UPPER_W], filt[P_DQ +: DATA_W]};
    assign wdata = filt[P_DQ +: DATA_W];

    // whole next state in one place
    always_comb
    begin
        next_st = st;
        next_st.s1 = {hw_reset_n_i, chip_sel_n_i, out_en_n_i, write_en_n_i,
            address_valid_n_i, bus_clk_i, upper_address_i,
            muxed_addr_data_i};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.pin = filt;
        next_st.prog_req = 1'b0;
        next_st.erase_req = 1'b0;

        // engine finished: the bank always falls back to read
        if (algo_done_i && st.mode == M_ALGO)
        begin
            next_st.mode = M_READ; // [R2]
            next_st.fail = algo_fail_i;
        end

        // address latch; output enable must still be high
        if (async_mode && avd_rise && sel && !rd_en)
            next_st.addr = pin_addr; // [R20]

        // command writes, taken at the write strobe rising edge
        if (we_rise && sel && !rd_en && !avd_lo) // [R14] [R5]
        begin
            if (st.prog_armed)
            begin
                next_st.prog_armed = 1'b0;
                next_st.prog_addr = st.addr;
                next_st.prog_data = wdata;
                next_st.prog_space = space_of(st, st.addr);
                if (st.mode == M_READ)
                begin
                    next_st.mode = M_ALGO;
                    next_st.act_bank = bank_of(st.addr);
                    next_st.prog_req = 1'b1;
                end
                else if (st.mode == M_OVL)
                begin
                    // only the overlaid area may be programmed
                    if (space_of(st, st.addr) == SP_ARRAY
                        || space_of(st, st.addr) == SP_ID
                        || (space_of(st, st.addr) == SP_OTP
                        && st.addr[DATA_W-1:0] < OTP_CUST_OFS))
                        next_st.fail = 1'b1; // [R13] [R12]
                    else
                    begin
                        next_st.mode = M_ALGO; // [R12]
                        next_st.prog_req = 1'b1;
                        if (space_of(st, st.addr) == SP_CFG)
                            next_st.cfg = wdata;
                    end
                end
            end
            else
            begin
                unique case (wdata[7:0])
                    CMD_RESET:
                    begin
                        // leaves any overlay, identification included
                        if (st.mode == M_OVL)
                            next_st.mode = M_READ; // [R23] [R2]
                        next_st.status_armed = 1'b0;
                    end
                    CMD_ID_A, CMD_ID_B, CMD_OTP, CMD_LOCK, CMD_CFG:
                    begin
                        // a busy bank anywhere blocks the entry
                        if (st.mode == M_READ) // [R9] [R1]
                        begin
                            next_st.mode = M_OVL;
                            next_st.act_bank = bank_of(st.addr);
                            next_st.ovl_sect = sect_of(st.addr);
                            next_st.status_armed = 1'b0;
                            if (wdata[7:0] == CMD_OTP)
                                next_st.ovl = SP_OTP;
                            else if (wdata[7:0] == CMD_LOCK)
                                next_st.ovl = SP_LOCK;
                            else if (wdata[7:0] == CMD_CFG)
                                next_st.ovl = SP_CFG;
                            else
                                next_st.ovl = SP_ID;
                        end
                    end
                    CMD_PROG:
                        next_st.prog_armed = st.mode != M_ALGO; // [R9]
                    CMD_ERASE:
                    begin
                        if (st.mode == M_READ) // [R9] [R1]
                        begin
                            next_st.mode = M_ALGO;
                            next_st.act_bank = bank_of(st.addr);
                            next_st.prog_addr = st.addr;
                            next_st.prog_space = SP_ARRAY;
                            next_st.erase_req = 1'b1;
                        end
                    end
                    CMD_STATUS:
                    begin
                        next_st.status_armed = 1'b1;
                        next_st.act_bank = st.mode == M_READ
                            ? bank_of(st.addr) : st.act_bank;
                    end
                    default:
                        next_st.prog_armed = 1'b0;
                endcase
            end
        end

        // bus sequencer
        unique case (st.bus)
            B_IDLE:
            begin
                next_st.dq_oe = 1'b0;
                next_st.cnt = '0;
                if (async_mode && sel && rd_en && !avd_lo)
                    next_st.bus = B_ASYNC;
            end
            B_ASYNC:
            begin
                // data only after the access time, while still enabled
                if (!(sel && rd_en && !avd_lo))
                begin
                    next_st.bus = B_IDLE;
                    next_st.dq_oe = 1'b0;
                end
                else if (st.cnt < 5'(ACC_CYC))
                    next_st.cnt = st.cnt + 5'h01;
                else
                begin
                    next_st.dq = read_word(st, st.addr, array_data_i);
                    next_st.dq_oe = 1'b1; // [R21]
                end
            end
            B_SYNC, B_HOLD:
            begin
                next_st.dq_oe = rd_en && st.bus == B_HOLD;
                if (bclk_rise && !avd_lo)
                begin
                    // one count per bus clock until the first word
                    if (st.cnt < iac_last)
                        next_st.cnt = st.cnt + 5'h01; // [R17]
                    if (next_st.cnt == iac_last && rd_en && we_hi)
                    begin
                        next_st.dq = read_word(st, st.addr, array_data_i);
                        next_st.addr = st.addr + ADDR_W'(1); // [R16]
                        next_st.bus = B_HOLD;
                    end
                end
            end
            default:
                next_st.bus = B_IDLE;
        endcase

        // burst address capture restarts the burst from any state
        if (!async_mode && bclk_rise && sel && !rd_en && we_hi && avd_lo)
        begin
            next_st.addr = pin_addr; // [R15]
            next_st.cnt = 5'h01;
            next_st.bus = B_SYNC;
            next_st.dq_oe = 1'b0;
        end

        // ready pin shows not ready only while a burst waits
        next_st.ready = !(next_st.bus == B_SYNC)
            ^ !st.cfg[CFG_RDY_POL]; // [R3] [R4]
        next_st.arr_addr = next_st.addr;
        next_st.arr_space = space_of(next_st, next_st.addr);

        // deselect floats the bus at once
        if (!sel)
        begin
            next_st.bus = B_IDLE;
            next_st.dq_oe = 1'b0; // [R24]
        end

        // pin reset and block reset share the mode reset
        if (rst_i || !filt[P_RST])
        begin
            next_st.bus = B_IDLE;
            next_st.dq_oe = 1'b0; // [R24]
            next_st.cfg = CFG_RESET; // [R18]
            next_st.mode = M_READ; // [R2]
            next_st.prog_armed = 1'b0;
            next_st.status_armed = 1'b0;
            next_st.prog_req = 1'b0;
            next_st.erase_req = 1'b0;
            next_st.cnt = '0;
        end
        if (rst_i)
        begin
            next_st.s1 = PIN_IDLE;
            next_st.s2 = PIN_IDLE;
            next_st.s3 = PIN_IDLE;
            next_st.pin = PIN_IDLE;
            next_st.addr = '0;
            next_st.act_bank = '0;
            next_st.ovl_sect = '0;
            next_st.ovl = SP_ID;
            next_st.fail = 1'b0;
            next_st.dq = '0;
            next_st.ready = CFG_RESET[CFG_RDY_POL];
            next_st.arr_addr = '0;
            next_st.arr_space = SP_ARRAY;
            next_st.prog_addr = '0;
            next_st.prog_data = '0;
            next_st.prog_space = SP_ARRAY;
        end
    end

    // single state register
    always_ff @(posedge clk_i)
    begin
        st <= next_st;
    end

    // every output straight from the state register
    assign muxed_addr_data_o = st.dq;
    assign muxed_addr_data_oe_o = st.dq_oe;
    assign ready_o = st.ready;
    assign array_addr_o = st.arr_addr;
    assign array_space_o = st.arr_space;
    assign prog_req_o = st.prog_req;
    assign erase_req_o = st.erase_req;
    assign prog_addr_o = st.prog_addr;
    assign prog_data_o = st.prog_data;
    assign prog_space_o = st.prog_space;
    assign active_bank_o = st.act_bank;
    assign bank_mode_o = st.mode;
endmodule : fbm_core

// [core/fbm_pkg.sv]
// constants and types shared by the flash bank mode and bus block
package fbm_pkg;
    // bus widths
    localparam int DATA_W = 16;
    localparam int UPPER_W = 13;
    localparam int ADDR_W = UPPER_W + DATA_W;

    // positions inside the sampled pin vector
    localparam int P_DQ = 0;
    localparam int P_UA = P_DQ + DATA_W;
    localparam int P_BCLK = P_UA + UPPER_W;
    localparam int P_AVD = P_BCLK + 1;
    localparam int P_WE = P_AVD + 1;
    localparam int P_OE = P_WE + 1;
    localparam int P_CS = P_OE + 1;
    localparam int P_RST = P_CS + 1;
    localparam int PIN_W = P_RST + 1;
    // strobes and resets idle high, bus clock and buses idle low
    localparam logic [PIN_W-1:0] PIN_IDLE =
        {5'h1F, 1'b0, 13'h0000, 16'h0000};

    // configuration register layout and reset value
    localparam int CFG_ASYNC = 15;
    localparam int CFG_IAC_HI = 14;
    localparam int CFG_IAC_LO = 11;
    localparam int CFG_RDY_POL = 10;
    localparam logic [DATA_W-1:0] CFG_RESET = 16'hBC00;
    // initial access cycles are the field code plus this offset
    localparam logic [4:0] IAC_OFS = 5'h02;

    // status word bits
    localparam int ST_READY = 7;
    localparam int ST_FAIL = 4;

    // command codes, low byte of the written word
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_ID_A = 8'h98;
    localparam logic [7:0] CMD_ID_B = 8'h90;
    localparam logic [7:0] CMD_OTP = 8'h88;
    localparam logic [7:0] CMD_LOCK = 8'h40;
    localparam logic [7:0] CMD_CFG = 8'h61;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h30;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    // word offset where the customer half of the one-time area starts
    localparam logic [DATA_W-1:0] OTP_CUST_OFS = 16'h0100;

    // asynchronous access time
    localparam int CLK_NS = 25;
    localparam int ACC_NS = 70;
    localparam int ACC_CYCLES = (ACC_NS + CLK_NS - 1) / CLK_NS;

    // address spaces seen by the array side
    typedef enum logic [2:0] {
        SP_ARRAY = 3'h0,
        SP_ID = 3'h1,
        SP_OTP = 3'h2,
        SP_LOCK = 3'h3,
        SP_CFG = 3'h4
    } fbm_space_type;

    // mode of the one bank that may leave read mode
    typedef enum logic [2:0] {
        M_READ = 3'b001,
        M_ALGO = 3'b010,
        M_OVL = 3'b100
    } fbm_mode_type;

    // bus sequencer
    typedef enum logic [3:0] {
        B_IDLE = 4'b0001,
        B_ASYNC = 4'b0010,
        B_SYNC = 4'b0100,
        B_HOLD = 4'b1000
    } fbm_bus_type;
endpackage : fbm_pkg

// [tb/fbm_core_checker.sv]
// port assertions for the bank mode and bus block
`timescale 1ns/100ps
module fbm_core_checker
#(
    parameter int BANK_W = 2
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host pins
    input wire logic hw_reset_n_i,
    input wire logic chip_sel_n_i,
    input wire logic out_en_n_i,
    input wire logic write_en_n_i,
    input wire logic address_valid_n_i,
    // design outputs and engine answer
    input wire logic muxed_addr_data_oe_o,
    input wire logic prog_req_o,
    input wire logic erase_req_o,
    input wire logic algo_done_i,
    input wire logic [BANK_W-1:0] active_bank_o,
    input wire fbm_pkg::fbm_mode_type bank_mode_o
);
    import fbm_pkg::*;

    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // pins pass three sync flops, hence the few cycles of slack
    a_deselect_float: assert property ($rose(chip_sel_n_i) |-> ##[1:6] !muxed_addr_data_oe_o)
        else $error("bus still driven after deselect");
    a_pin_reset_read: assert property ($fell(hw_reset_n_i) |-> ##[1:6] (!muxed_addr_data_oe_o && bank_mode_o == M_READ))
        else $error("pin reset did not float bus and restore read");
    a_mode_single: assert property ($onehot(bank_mode_o))
        else $error("bank mode not a single mode");
    a_drive_selected: assert property ($rose(muxed_addr_data_oe_o) |-> !chip_sel_n_i && !out_en_n_i && address_valid_n_i)
        else $error("bus driven without select and enable");
    a_quiet_no_cmd: assert property (write_en_n_i [*8] |-> !prog_req_o && !erase_req_o)
        else $error("request without a write cycle");
    a_erase_algo: assert property (erase_req_o |-> ##[0:1] bank_mode_o == M_ALGO)
        else $error("erase without algorithm mode");
    a_erase_from_read: assert property (erase_req_o |-> $past(bank_mode_o, 2) == M_READ)
        else $error("erase accepted outside read mode");
    a_done_read: assert property (algo_done_i && bank_mode_o == M_ALGO |=> bank_mode_o == M_READ)
        else $error("bank stays busy after done");

    // main scenarios reached
    c_erase: cover property (erase_req_o);
    c_read: cover property ($rose(muxed_addr_data_oe_o));
    c_overlay: cover property (bank_mode_o == M_OVL);
endmodule : fbm_core_checker

// [tb/fbm_host_model.sv]
// host bus controller model driving the multiplexed flash pins
`timescale 1ns/100ps
module fbm_host_model
(
    // clock
    input wire logic clk_i,
    // device side of the shared bus
    input wire logic [fbm_pkg::DATA_W-1:0] dev_data_i,
    input wire logic dev_oe_i,
    // host pins
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic avd_n_o,
    output logic [fbm_pkg::UPPER_W-1:0] upper_o,
    output logic [fbm_pkg::DATA_W-1:0] bus_o
);
    import fbm_pkg::*;
    logic [DATA_W-1:0] hd;

    // the device wins the wire while it drives; a released host shows
    // the inverse of its last value so stale data cannot pass
    assign bus_o = dev_oe_i ? dev_data_i : hd;

    // idle pins
    initial
    begin
        cs_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        avd_n_o = 1'b1;
        upper_o = 13'h0000;
        hd = 16'h0000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // each pin step lasts four clocks, longer than the sync delay
    task automatic addr_ph(input logic [ADDR_W-1:0] a);
        cs_n_o <= 1'b0;
        avd_n_o <= 1'b0;
        upper_o <= a[ADDR_W-1:DATA_W];
        hd <= a[DATA_W-1:0]; // output and write enable stay high
        tick(4);
        avd_n_o <= 1'b1; // rising edge latches the address
        tick(4);
    endtask : addr_ph

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr_ph(a);
        hd <= d;
        we_n_o <= 1'b0;
        tick(4);
        we_n_o <= 1'b1; // data held across the strobe rise
        tick(4);
        cs_n_o <= 1'b1;
        hd <= ~d;
        tick(4);
    endtask : wr

    // data taken at the edge where the drive enable is seen high
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
        output bit ok);
        ok = 1'b0;
        d = 16'h0000;
        addr_ph(a);
        hd <= ~hd;
        oe_n_o <= 1'b0; // enabled only after the latch edge
        for (int i = 0; i < 24 && !ok; i++)
        begin
            @(posedge clk_i);
            if (dev_oe_i === 1'b1)
            begin
                ok = 1'b1;
                d = dev_data_i;
            end
        end
        oe_n_o <= 1'b1;
        cs_n_o <= 1'b1;
        tick(6);
    endtask : rd
endmodule : fbm_host_model

// [tb/fbm_core_tb.sv]
// self-checking bench for the flash bank mode and bus block
`timescale 1ns/100ps
module fbm_core_tb;
    import fbm_pkg::*;
    localparam logic [ADDR_W-1:0] A0 = 29'h0000_1238;
    localparam logic [ADDR_W-1:0] S1 = 29'h0001_0004;
    localparam logic [ADDR_W-1:0] B1 = 29'h0800_0040;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_reset_n_i = 1'b1;
    logic algo_done_i = 1'b0;
    logic [DATA_W-1:0] arr_d = 16'h0000;
    logic cs_n, oe_n, we_n, avd_n, dq_oe, ready, prog_req, erase_req;
    logic [UPPER_W-1:0] upper;
    logic [DATA_W-1:0] bus, dq, prog_data;
    logic [ADDR_W-1:0] arr_a, prog_addr;
    fbm_space_type arr_s, prog_space;
    logic [1:0] bank;
    fbm_mode_type mode;
    int err_count = 0;
    int cmp_count = 0;
    int n_erase = 0;
    int n_prog = 0;

    always #12.5 clk_i = ~clk_i;

    fbm_host_model host (.clk_i(clk_i), .dev_data_i(dq), .dev_oe_i(dq_oe),
        .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n), .avd_n_o(avd_n),
        .upper_o(upper), .bus_o(bus));

    fbm_core dut (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i),
        .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_en_n_i(we_n),
        .address_valid_n_i(avd_n), .bus_clk_i(1'b0), .upper_address_i(upper),
        .muxed_addr_data_i(bus), .muxed_addr_data_o(dq),
        .muxed_addr_data_oe_o(dq_oe), .ready_o(ready), .array_addr_o(arr_a),
        .array_space_o(arr_s), .array_data_i(arr_d), .prog_req_o(prog_req),
        .erase_req_o(erase_req), .prog_addr_o(prog_addr),
        .prog_data_o(prog_data), .prog_space_o(prog_space),
        .algo_done_i(algo_done_i), .algo_fail_i(1'b0),
        .active_bank_o(bank), .bank_mode_o(mode));

    // array content tags each word with its space code
    function automatic logic [15:0] av(input logic [2:0] s,
        input logic [ADDR_W-1:0] a);
        return {a[15:3], s};
    endfunction : av

    // array answers one clock after the address; requests are counted
    always @(posedge clk_i)
    begin
        arr_d <= av(arr_s, arr_a);
        if (erase_req === 1'b1)
            n_erase++;
        if (prog_req === 1'b1)
            n_prog++;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [63:0] got, input logic [63:0] exp,
        input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // a read that never answers ends the run
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        bit ok;
        host.rd(a, d, ok);
        if (!ok)
        begin
            err_count++;
            $display("BAD %0t read timeout", $time);
            finish_test();
        end
    endtask : rd

    task automatic done_pulse();
        algo_done_i <= 1'b1;
        @(posedge clk_i);
        algo_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : done_pulse

    task automatic t_reset();
        check(dq_oe, 1'b0, "oe");
        check(ready, 1'b1, "ready");
        check(mode, M_READ, "mode");
        check({prog_req, erase_req}, 2'b00, "req");
        $display("reset test done");
    endtask : t_reset

    task automatic t_async();
        logic [15:0] d;
        rd(A0, d);
        check(d, av(SP_ARRAY, A0), "async data");
        check(arr_a, A0, "latched addr");
        check(dq_oe, 1'b0, "float");
        $display("async test done");
    endtask : t_async

    task automatic t_erase();
        logic [15:0] d;
        host.wr(B1, {8'h00, CMD_ERASE});
        check(n_erase, 1, "erase req");
        check({bank, mode}, {2'h1, M_ALGO}, "busy bank");
        rd(B1, d);
        check(d, 16'h0000, "hidden array");
        rd(A0, d);
        check(d, av(SP_ARRAY, A0), "other bank");
        host.wr(A0, {8'h00, CMD_ID_A});
        check({bank, mode}, {2'h1, M_ALGO}, "entry ignored");
        host.wr(B1, {8'h00, CMD_STATUS});
        rd(B1, d);
        check(d[ST_READY], 1'b0, "status busy");
        done_pulse();
        check(mode, M_READ, "after done");
        $display("erase test done");
    endtask : t_erase

    task automatic t_ident();
        logic [15:0] d;
        host.wr(S1, {8'h00, CMD_ID_A}); // erase already done
        check(mode, M_OVL, "overlay");
        rd(S1, d);
        check(d, av(SP_ID, S1), "id sector");
        rd(A0, d);
        check(d, av(SP_ARRAY, A0), "same bank");
        host.wr(S1, {8'h00, CMD_PROG});
        host.wr(S1, 16'h1234);
        check(n_prog, 0, "id program");
        host.wr(B1, {8'h00, CMD_ERASE});
        check(n_erase, 1, "erase in overlay");
        // recovery command with a non-zero high byte
        host.wr(A0, 16'hABF0);
        check(mode, M_READ, "overlay exit");
        rd(S1, d);
        check(d, av(SP_ARRAY, S1), "array back");
        $display("ident test done");
    endtask : t_ident

    task automatic t_otp();
        logic [ADDR_W-1:0] c;
        c = {S1[ADDR_W-1:DATA_W], OTP_CUST_OFS};
        host.wr(S1, {8'h00, CMD_OTP});
        host.wr(S1, {8'h00, CMD_PROG});
        host.wr(S1, 16'h5555);
        check(n_prog, 0, "factory half");
        check(mode, M_OVL, "still overlay");
        host.wr(S1, {8'h00, CMD_PROG});
        host.wr(c, 16'hC3A5);
        check(n_prog, 1, "otp program");
        check({prog_addr, prog_data}, {c, 16'hC3A5}, "prog word");
        check({prog_space, mode}, {SP_OTP, M_ALGO}, "prog mode");
        done_pulse();
        check(mode, M_READ, "after program");
        $display("otp test done");
    endtask : t_otp

    task automatic t_pin_reset();
        logic [15:0] d;
        host.wr(S1, {8'h00, CMD_ID_B});
        check(mode, M_OVL, "id entry");
        hw_reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check(dq_oe, 1'b0, "float");
        hw_reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check(mode, M_READ, "pin reset");
        rd(S1, d);
        check(d, av(SP_ARRAY, S1), "async default");
        $display("pin reset test done");
    endtask : t_pin_reset

    // reset for two clocks, then the scenarios in order
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_async();
        t_erase();
        t_ident();
        t_otp();
        t_pin_reset();
        finish_test();
    end
endmodule : fbm_core_tb

bind fbm_core fbm_core_checker #(.BANK_W(BANK_W)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i), .chip_sel_n_i(chip_sel_n_i),
    .out_en_n_i(out_en_n_i), .write_en_n_i(write_en_n_i),
    .address_valid_n_i(address_valid_n_i),
    .muxed_addr_data_oe_o(muxed_addr_data_oe_o), .prog_req_o(prog_req_o),
    .erase_req_o(erase_req_o), .algo_done_i(algo_done_i),
    .active_bank_o(active_bank_o), .bank_mode_o(bank_mode_o));
